// *** smp_core.sv ***
// Purpose: Executes maintenance procedures and holds their objects.
// Assumes: presetn is the power-up event; drive logic shares pclk.
// Notes: APB answers with one wait state; pslverr on unmapped words.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module smp_core
	import smp_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS,
	parameter int TUNE_N_LOG2 = TUNE_LOG2
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SMP_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Drive state.
	input wire logic servo_on,
	input wire logic alarm_active,
	input wire logic [15:0] overload_now,
	// Encoder.
	input wire smp_enc_t enc,
	input wire logic enc_index_pin,
	input wire logic enc_reset_done,
	output logic enc_reset_req,
	// Current sensing.
	input wire logic phase_valid,
	input wire smp_phase_t phase_samples,
	output logic phase_offset_alarm,
	// Motor commands.
	output logic vel_en,
	output logic [15:0] vel_cmd,
	output logic align_en,
	output logic [15:0] align_method,
	output logic [15:0] align_current,
	output logic soft_reset_req,
	output logic busy
);
	smp_state_t state_q;
	logic [15:0] proc_cmd_q, proc_arg_q, abs_cfg_q, abs_cfg_act_q;
	logic [15:0] lin_res_q, aln_time_q, search_spd_q, peak_q;
	smp_phase_t ph_ofs_q, tune_avg;
	logic [31:0] home_ofs_q, pos_act_q, multi_q, single_q;
	logic [31:0] ms_cnt_q;
	logic [15:0] ms_q;
	logic reload_q, refused_q, servo_q, idx_sync, idx_q, idx_rise;
	logic tune_start, tune_done, tune_big;
	logic acc, wr, cmd_wr, motion, legal, accept;
	logic [SMP_IW-1:0] idx;
	logic [31:0] rdata;
	logic mapped;
	logic [15:0] wcode;

	smp_sync2 u_idx_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(enc_index_pin),
		.sync_out(idx_sync)
	);

	smp_offset_acc #(.LOG2N(TUNE_N_LOG2)) u_ofs (
		.pclk(pclk),
		.presetn(presetn),
		.start(tune_start),
		.sample_valid(phase_valid),
		.samples(phase_samples),
		.done(tune_done),
		.avg(tune_avg),
		.too_large(tune_big)
	);

	// Bus decode; a write counts only at the edge that completes it.
	assign idx = paddr[SMP_AW-1:2];
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && mapped;
	assign wcode = pwdata[15:0];
	assign cmd_wr = wr && (idx == IDX_PROC_CMD);
	// Procedures that move or energise the motor need servo off.
	assign motion = (wcode == PC_SEARCH) || (wcode == PC_ENC_RST) ||
		(wcode == PC_TUNE) || (wcode == PC_ALIGN);
	assign legal = (wcode >= PC_SEARCH) && (wcode <= PC_ALIGN);
	assign accept = cmd_wr && legal && (state_q == SMP_IDLE) &&
		!(motion && (servo_on || alarm_active));
	assign tune_start = accept && (wcode == PC_TUNE);
	assign idx_rise = idx_sync && !idx_q;

	// Read mux; reserved bits read as zero.
	always_comb
	begin
		rdata = ZERO32;
		mapped = 1'b1;
		unique case (idx)
			IDX_ABS_CFG: rdata[15:0] = abs_cfg_q;
			IDX_PH_A: rdata[15:0] = ph_ofs_q[0];
			IDX_PH_B: rdata[15:0] = ph_ofs_q[1];
			IDX_PH_C: rdata[15:0] = ph_ofs_q[2];
			IDX_LIN_RES: rdata[15:0] = lin_res_q;
			IDX_ALN_METHOD: rdata[15:0] = align_method;
			IDX_ALN_CURRENT: rdata[15:0] = align_current;
			IDX_ALN_TIME: rdata[15:0] = aln_time_q;
			IDX_SEARCH_SPD: rdata[15:0] = search_spd_q;
			IDX_PEAK: rdata[15:0] = peak_q;
			IDX_SINGLE: rdata = single_q;
			IDX_MULTI: rdata = multi_q;
			IDX_POS_ACT: rdata = pos_act_q;
			IDX_PROC_CMD: rdata[15:0] = proc_cmd_q;
			IDX_PROC_ARG: rdata[15:0] = proc_arg_q;
			IDX_HOME_OFS: rdata = home_ofs_q;
			IDX_STATUS:
			begin
				rdata[ST_BUSY] = busy;
				rdata[ST_SERVO] = servo_on;
				rdata[ST_ALARM] = alarm_active;
				rdata[ST_REFUSED] = refused_q;
				rdata[ST_PH_ALARM] = phase_offset_alarm;
				rdata[ST_CFG_LSB +: 16] = abs_cfg_act_q;
			end
			default: mapped = 1'b0;
		endcase
		if (paddr[1:0] != 2'b00)
			mapped = 1'b0;
	end

	// One wait state keeps pready and prdata straight from flops.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= ZERO32;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			prdata <= (psel && penable && !pready && !pwrite) ? rdata : ZERO32;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// Software-written parameters; abs_cfg_q and home_ofs_q act only after a reload.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			abs_cfg_q <= ABS_CFG_RST;
			lin_res_q <= ZERO16;
			align_method <= ZERO16;
			align_current <= ZERO16;
			aln_time_q <= ZERO16;
			search_spd_q <= ZERO16;
			home_ofs_q <= ZERO32;
			proc_arg_q <= ZERO16;
		end
		else if (wr)
		begin
			unique case (idx)
				IDX_ABS_CFG: abs_cfg_q <= wcode;
				IDX_LIN_RES: lin_res_q <= wcode;
				IDX_ALN_METHOD: align_method <= wcode;
				IDX_ALN_CURRENT: align_current <= wcode;
				IDX_ALN_TIME: aln_time_q <= wcode;
				IDX_SEARCH_SPD: search_spd_q <= wcode;
				IDX_HOME_OFS: home_ofs_q <= pwdata;
				IDX_PROC_ARG: proc_arg_q <= wcode;
				default: ;
			endcase
		end
	end

	// Command object only takes codes that are accepted.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			proc_cmd_q <= ZERO16;
		else if (accept)
			proc_cmd_q <= wcode;
	end

	// Refusal flag; a new refusal wins over a write-one clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refused_q <= 1'b0;
		else if (cmd_wr && !accept)
			refused_q <= 1'b1;
		else if (wr && idx == IDX_STATUS && pwdata[ST_REFUSED])
			refused_q <= 1'b0;
	end

	// Phase offsets: software may write, tuning overwrites them.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ph_ofs_q <= '0;
		else if (tune_done)
			ph_ofs_q <= tune_avg;
		else if (wr && idx == IDX_PH_A)
			ph_ofs_q[0] <= wcode;
		else if (wr && idx == IDX_PH_B)
			ph_ofs_q[1] <= wcode;
		else if (wr && idx == IDX_PH_C)
			ph_ofs_q[2] <= wcode;
	end

	// Phase offset alarm is sticky; setting beats the clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_offset_alarm <= 1'b0;
		else if (tune_done && tune_big)
			phase_offset_alarm <= 1'b1;
		else if (wr && idx == IDX_STATUS && pwdata[ST_PH_ALARM])
			phase_offset_alarm <= 1'b0;
	end

	// Reload acts as power-up: constant at reset, again on code nine.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reload_q <= 1'b1;
		else
			reload_q <= accept && (wcode == PC_SOFT_RST);
	end

	// Power-up-only parameters and the position actual value.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			abs_cfg_act_q <= ABS_CFG_RST;
			pos_act_q <= ZERO32;
		end
		else if (reload_q)
		begin
			abs_cfg_act_q <= abs_cfg_q;
			pos_act_q <= enc.abs_pos + home_ofs_q;
		end
	end

	// Turn counts follow the encoder but read zero when reset ends.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			multi_q <= ZERO32;
			single_q <= ZERO32;
		end
		else if (state_q == SMP_ENC_RST && enc_reset_done)
		begin
			multi_q <= ZERO32;
			single_q <= ZERO32;
		end
		else
		begin
			multi_q <= enc.multi;
			single_q <= enc.single;
		end
	end

	// Peak overload since servo-on; cleared by code seven or power-up.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			peak_q <= ZERO16;
			servo_q <= 1'b0;
		end
		else
		begin
			servo_q <= servo_on;
			if (reload_q || (accept && wcode == PC_PEAK_CLR))
				peak_q <= ZERO16;
			else if (servo_on && !servo_q)
				peak_q <= ZERO16;
			else if (servo_on && overload_now > peak_q)
				peak_q <= overload_now;
		end
	end

	// Procedure sequencer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= SMP_IDLE;
		else
		begin
			unique case (state_q)
				SMP_IDLE:
					if (accept && wcode == PC_SEARCH)
						state_q <= SMP_SEARCH;
					else if (accept && wcode == PC_ENC_RST)
						state_q <= SMP_ENC_RST;
					else if (tune_start)
						state_q <= SMP_TUNE;
					else if (accept && wcode == PC_ALIGN)
						state_q <= SMP_ALIGN;
				SMP_SEARCH:
					if (idx_rise || alarm_active)
						state_q <= SMP_IDLE;
				SMP_ENC_RST:
					if (enc_reset_done)
						state_q <= SMP_IDLE;
				SMP_TUNE:
					if (tune_done)
						state_q <= SMP_IDLE;
				SMP_ALIGN:
					if (alarm_active || (ms_q >= aln_time_q && ms_q != 0))
						state_q <= SMP_IDLE;
			endcase
		end
	end

	// Millisecond timer for rotor alignment.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt_q <= ZERO32;
			ms_q <= ZERO16;
		end
		else if (state_q != SMP_ALIGN)
		begin
			ms_cnt_q <= ZERO32;
			ms_q <= ZERO16;
		end
		else if (ms_cnt_q == 32'(CYC_MS - 1))
		begin
			ms_cnt_q <= ZERO32;
			ms_q <= ms_q + 16'h0001;
		end
		else
			ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
	end

	// Registered motor commands and request pulses.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idx_q <= 1'b0;
			vel_en <= 1'b0;
			vel_cmd <= ZERO16;
			align_en <= 1'b0;
			enc_reset_req <= 1'b0;
			soft_reset_req <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			idx_q <= idx_sync;
			vel_en <= (state_q == SMP_SEARCH) && !idx_rise && !alarm_active;
			vel_cmd <= search_spd_q;
			align_en <= (state_q == SMP_ALIGN);
			enc_reset_req <= accept && (wcode == PC_ENC_RST);
			soft_reset_req <= accept && (wcode == PC_SOFT_RST);
			busy <= (state_q != SMP_IDLE) || accept;
		end
	end

	sequence s_soft_cmd;
		accept && wcode == PC_SOFT_RST;
	endsequence
	sequence s_reload_seen;
		soft_reset_req && reload_q ##1 peak_q == ZERO16;
	endsequence

	a_refuse_motion: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && motion && servo_on |=> $stable(proc_cmd_q))
		else $error("motion code taken while servo on");
	a_search_stop: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SMP_SEARCH && idx_rise |=> !vel_en ##1 !vel_en)
		else $error("search did not stop at index");
	a_search_speed: assert property (@(posedge pclk) disable iff (!presetn)
		vel_en |-> vel_cmd == $past(search_spd_q) &&
		$past(state_q) == SMP_SEARCH)
		else $error("search speed differs from setting");
	a_enc_zero: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SMP_ENC_RST && enc_reset_done |=> multi_q == 0 &&
		single_q == 0 && state_q == SMP_IDLE)
		else $error("turn counts not zero after encoder reset");
	a_pos_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!reload_q |=> $stable(pos_act_q))
		else $error("position actual moved outside power-up");
	a_peak_clear: assert property (@(posedge pclk) disable iff (!presetn)
		accept && wcode == PC_PEAK_CLR |=> peak_q == ZERO16)
		else $error("peak not cleared by procedure");
	a_peak_track: assert property (@(posedge pclk) disable iff (!presetn)
		servo_on && servo_q && !reload_q && !accept && overload_now > peak_q
		|=> peak_q == $past(overload_now))
		else $error("peak missed a larger overload");
	a_tune_store: assert property (@(posedge pclk) disable iff (!presetn)
		tune_done |=> ph_ofs_q == $past(tune_avg) && state_q == SMP_IDLE)
		else $error("tuned offsets not stored");
	a_tune_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		tune_done && tune_big |=> phase_offset_alarm [*2])
		else $error("phase offset alarm not raised");
	a_soft_reload: assert property (@(posedge pclk) disable iff (!presetn)
		s_soft_cmd |=> s_reload_seen)
		else $error("software reset did not reload");
	a_align_hold: assert property (@(posedge pclk) disable iff (!presetn)
		accept && wcode == PC_ALIGN && !alarm_active
		|=> ##1 align_en [*3])
		else $error("alignment ended too early");
endmodule

// *** smp_pkg.sv ***
// Purpose: Shared constants and types of the maintenance procedure block.
// Assumes: One 25 MHz clock; object indices are word indices on APB.
// Notes: Byte address of an object is four times its index.
// How it works
// - Host writes code and argument; device runs it.
// - Code five runs the index pulse search.
// - Code six resets encoder; seven clears peak.
// - Eight tunes offsets, nine resets, ten commutates.
// - Search runs at set speed, stops on index.
// - Encoder reset zeroes multi-turn and single-turn counts.
// - Position actual keeps old value until power-up.
// - Power-up loads encoder position plus home offset.
// - Home offset change leaves position actual alone.
// - Peak overload reset procedure clears peak to zero.
// - Peak holds largest overload since servo-on.
// - Power-up clears the peak overload value.
// - Tuning writes three measured signed phase offsets.
// - Abnormally large offset raises the phase alarm.
// - Software reset acts like reapplying power.
// - Commutation aligns rotor using method, current, time.
// - Power-up parameters apply only after power cycle.
package smp_pkg;
	localparam int SMP_AW = 16;
	localparam int SMP_IW = 14;
	// Object indices; byte address is index times four.
	localparam logic [13:0] IDX_ABS_CFG = 14'h2005;
	localparam logic [13:0] IDX_PH_A = 14'h2015;
	localparam logic [13:0] IDX_PH_B = 14'h2016;
	localparam logic [13:0] IDX_PH_C = 14'h2017;
	localparam logic [13:0] IDX_LIN_RES = 14'h2019;
	localparam logic [13:0] IDX_ALN_METHOD = 14'h201a;
	localparam logic [13:0] IDX_ALN_CURRENT = 14'h201b;
	localparam logic [13:0] IDX_ALN_TIME = 14'h201c;
	localparam logic [13:0] IDX_SEARCH_SPD = 14'h230c;
	localparam logic [13:0] IDX_PEAK = 14'h2604;
	localparam logic [13:0] IDX_SINGLE = 14'h2607;
	localparam logic [13:0] IDX_MULTI = 14'h260a;
	localparam logic [13:0] IDX_POS_ACT = 14'h262a;
	localparam logic [13:0] IDX_PROC_CMD = 14'h2700;
	localparam logic [13:0] IDX_PROC_ARG = 14'h2701;
	localparam logic [13:0] IDX_STATUS = 14'h27f0;
	localparam logic [13:0] IDX_HOME_OFS = 14'h3019;
	// Procedure codes.
	localparam logic [15:0] PC_SEARCH = 16'h0005;
	localparam logic [15:0] PC_ENC_RST = 16'h0006;
	localparam logic [15:0] PC_PEAK_CLR = 16'h0007;
	localparam logic [15:0] PC_TUNE = 16'h0008;
	localparam logic [15:0] PC_SOFT_RST = 16'h0009;
	localparam logic [15:0] PC_ALIGN = 16'h000a;
	// Reset values.
	localparam logic [15:0] ABS_CFG_RST = 16'h0001;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// Status register field positions.
	localparam int ST_BUSY = 0;
	localparam int ST_SERVO = 1;
	localparam int ST_ALARM = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_PH_ALARM = 4;
	localparam int ST_CFG_LSB = 16;
	// Timing: the millisecond tick of the commutation timer.
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	// Offset tuning: samples averaged and the alarm limit in 0.1 %.
	localparam int TUNE_LOG2 = 4;
	localparam logic signed [15:0] OFS_LIMIT = 16'sh00c8;
	typedef enum logic [2:0] {
		SMP_IDLE, SMP_SEARCH, SMP_ENC_RST, SMP_TUNE, SMP_ALIGN
	} smp_state_t;
	typedef struct packed {
		logic [31:0] abs_pos;
		logic [31:0] multi;
		logic [31:0] single;
	} smp_enc_t;
	typedef logic [2:0][15:0] smp_phase_t;
endpackage

// *** smp_sync2.sv ***
// Purpose: Two-flop synchroniser for a level from a pin.
// Assumes: Input is asynchronous to pclk.
// Notes: The first flop feeds only the second one.
`timescale 1ns/1ps
module smp_sync2
	import smp_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Level in and out.
	input wire logic async_in,
	output logic sync_out
);
	logic meta_q;

	// Both stages reset low so a stuck pin is seen after two edges.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// *** smp_offset_acc.sv ***
// Purpose: Averages phase current samples to find their offsets.
// Assumes: Samples arrive on sample_valid from same-clock logic.
// Notes: Average is a plain arithmetic shift of the sum.
`timescale 1ns/1ps
module smp_offset_acc
	import smp_pkg::*;
#(
	parameter int LOG2N = TUNE_LOG2
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control.
	input wire logic start,
	input wire logic sample_valid,
	input wire smp_phase_t samples,
	// Results.
	output logic done,
	output smp_phase_t avg,
	output logic too_large
);
	logic [LOG2N:0] cnt_q;
	logic run_q;
	logic [2:0] over;
	logic signed [LOG2N+15:0] sum_q [3];

	// Sample counter; done pulses once the last sample is summed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q <= '0;
				run_q <= 1'b1;
			end
			else if (run_q && sample_valid)
			begin
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == (LOG2N+1)'((1 << LOG2N) - 1))
				begin
					run_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

	// One accumulator per phase; the limit check uses the magnitude.
	for (genvar p = 0; p < 3; p++)
	begin : g_phase
		logic signed [15:0] mean;
		assign mean = 16'(sum_q[p] >>> LOG2N);
		assign avg[p] = mean;
		assign over[p] = (mean > OFS_LIMIT) || (mean < -OFS_LIMIT);
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				sum_q[p] <= '0;
			else if (start)
				sum_q[p] <= '0;
			else if (run_q && sample_valid)
				sum_q[p] <= sum_q[p] + (LOG2N+16)'(signed'(samples[p]));
		end
	end
	assign too_large = |over;
endmodule

// *** smp_partner.sv ***
// Purpose: Encoder and current sensing on the far side of the block.
// Assumes: Same clock as the block; no real motor dynamics.
// Notes: Index pulse and reset answer follow fixed short delays.
`timescale 1ns/1ps
module smp_partner
	import smp_pkg::*;
#(
	parameter logic [31:0] POS0 = 32'h0003_2345
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Requests from the block.
	input wire logic vel_en,
	input wire logic enc_reset_req,
	// Sample values to send.
	input wire smp_phase_t phase_set,
	// Encoder side.
	output smp_enc_t enc,
	output logic enc_index_pin,
	output logic enc_reset_done,
	// Current sensing.
	output logic phase_valid,
	output smp_phase_t phase_samples
);
	logic [7:0] run_q;
	logic [3:0] rst_q;
	logic [1:0] ph_q;
	smp_enc_t enc_q = {POS0, 32'h0000_0003, {16'h0000, POS0[15:0]}};
	// Motion time; the index shows up only while the motor turns.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			run_q <= 8'h00;
		else
			run_q <= vel_en ? run_q + 8'h01 : 8'h00;
	assign enc_index_pin = (run_q >= 8'd40) && (run_q < 8'd44);
	// Encoder answers a reset request a few cycles later.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rst_q <= 4'h0;
		else
			rst_q <= {rst_q[2:0], enc_reset_req};
	assign enc_reset_done = rst_q[3];
	// Absolute position survives power loss, so no reset term here.
	always_ff @(posedge pclk)
		if (enc_reset_done)
			enc_q <= '0;
	assign enc = enc_q;
	// Samples are valid one cycle in four; between them junk is shown.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ph_q <= 2'h0;
		else
			ph_q <= ph_q + 2'h1;
	assign phase_valid = (ph_q == 2'h0);
	assign phase_samples = phase_valid ? phase_set : ~phase_set;
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench of the maintenance procedure block.
// Assumes: Short millisecond and sample counts set by parameters.
// Notes: Each wait is bounded; a hang ends in the closing report.
`timescale 1ns/1ps
`define CHK(g, e) \
begin \
	num_checks++; \
	if ((g) !== (e)) \
	begin \
		err_total++; \
		$display("unexpected t=%0t got %h exp %h", $time, g, e); \
	end \
end
module tb;
	import smp_pkg::*;
	localparam logic [31:0] POS0 = 32'h0003_2345;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic servo_on = 1'b0;
	logic alarm_active = 1'b0;
	logic [15:0] overload_now = 16'h0000;
	smp_phase_t phase_set = '0;
	logic [31:0] prdata, rd_q;
	logic pready, pslverr, er_q, busy, sr_seen;
	smp_enc_t enc;
	logic enc_index_pin, enc_reset_done, enc_reset_req, phase_valid;
	smp_phase_t phase_samples;
	logic phase_offset_alarm, vel_en, align_en, soft_reset_req;
	logic [15:0] vel_cmd, align_method, align_current, lf, mx, pa, hofs;
	int err_total = 0;
	int num_checks = 0;
	int aln_cnt = 0;
	int n;

	// The clock toggles every half period of 40 ns.
	always #20 pclk = ~pclk;

	smp_core #(.CYC_MS(10), .TUNE_N_LOG2(2)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.servo_on(servo_on), .alarm_active(alarm_active),
		.overload_now(overload_now), .enc(enc),
		.enc_index_pin(enc_index_pin), .enc_reset_done(enc_reset_done),
		.enc_reset_req(enc_reset_req), .phase_valid(phase_valid),
		.phase_samples(phase_samples),
		.phase_offset_alarm(phase_offset_alarm), .vel_en(vel_en),
		.vel_cmd(vel_cmd), .align_en(align_en),
		.align_method(align_method), .align_current(align_current),
		.soft_reset_req(soft_reset_req), .busy(busy));
	smp_partner #(.POS0(POS0)) far (.pclk(pclk), .presetn(presetn),
		.vel_en(vel_en), .enc_reset_req(enc_reset_req),
		.phase_set(phase_set), .enc(enc), .enc_index_pin(enc_index_pin),
		.enc_reset_done(enc_reset_done), .phase_valid(phase_valid),
		.phase_samples(phase_samples));

	// Watch one-cycle pulses and alignment time that tasks cannot see.
	always @(posedge pclk)
	begin
		if (soft_reset_req === 1'b1)
			sr_seen <= 1'b1;
		if (align_en === 1'b1)
			aln_cnt <= aln_cnt + 1;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Position after a power-up load is encoder position plus offset.
	function automatic logic [31:0] exp_pos(input logic [31:0] a,
		input logic [15:0] h);
		return a + {16'h0000, h};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer; entered just after a rising edge.
	task automatic apb(input logic wr, input logic [13:0] idx,
		input logic [31:0] wd);
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			err_total++;
			tally_and_finish();
		end
		rd_q = prdata;
		er_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [13:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0000_0000);
		`CHK(rd_q, e)
	endtask

	task automatic cmd(input logic [15:0] c);
		apb(1'b1, IDX_PROC_CMD, {16'h0000, c});
	endtask

	// Busy rises at the same edge that takes the write; still skip two edges first.
	task automatic wait_idle();
		repeat (2) @(posedge pclk);
		for (n = 0; n < 3000 && busy !== 1'b0; n++)
			@(posedge pclk);
		if (n >= 3000)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask

	initial
	begin
		lf = 16'he782;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(IDX_ABS_CFG, {16'h0000, ABS_CFG_RST});
		rdc(IDX_PEAK, ZERO32);
		rdc(IDX_POS_ACT, POS0);
		apb(1'b0, 14'h0100, 32'h0000_0000);
		`CHK(er_q, 1'b1)
		// Search with the servo off and no alarm, as an operator must.
		lf = lfsr_next(lf);
		apb(1'b1, IDX_SEARCH_SPD, {16'h0000, lf});
		// The argument object keeps the low half; upper bits are dropped.
		apb(1'b1, IDX_PROC_ARG, {16'hffff, lf});
		rdc(IDX_PROC_ARG, {16'h0000, lf});
		cmd(PC_SEARCH);
		for (n = 0; n < 50 && vel_en !== 1'b1; n++)
			@(posedge pclk);
		`CHK(vel_cmd, lf)
		`CHK(vel_en, 1'b1)
		// A command while a procedure runs is refused; the command object keeps its value.
		cmd(PC_PEAK_CLR);
		rdc(IDX_PROC_CMD, {16'h0000, PC_SEARCH});
		wait_idle();
		`CHK(vel_en, 1'b0)
		// Motion requests while the servo is on or an alarm is active.
		servo_on <= 1'b1;
		cmd(PC_ALIGN);
		rdc(IDX_PROC_CMD, {16'h0000, PC_SEARCH});
		rdc(IDX_STATUS, 32'h0001_000a);
		servo_on <= 1'b0;
		alarm_active <= 1'b1;
		cmd(PC_ENC_RST);
		rdc(IDX_PROC_CMD, {16'h0000, PC_SEARCH});
		alarm_active <= 1'b0;
		apb(1'b1, IDX_STATUS, 32'h0000_0008);
		rdc(IDX_STATUS, 32'h0001_0000);
		// Encoder reset zeroes counts but not the loaded position.
		cmd(PC_ENC_RST);
		wait_idle();
		rdc(IDX_MULTI, ZERO32);
		rdc(IDX_SINGLE, ZERO32);
		rdc(IDX_POS_ACT, POS0);
		lf = lfsr_next(lf);
		hofs = lf & 16'h7fff;
		apb(1'b1, IDX_HOME_OFS, {16'h0000, hofs});
		rdc(IDX_POS_ACT, POS0);
		// Peak follows the largest random load since servo-on.
		servo_on <= 1'b1;
		repeat (3) @(posedge pclk);
		mx = 16'h0000;
		for (int i = 0; i < 12; i++)
		begin
			lf = lfsr_next(lf);
			overload_now <= lf;
			mx = (lf > mx) ? lf : mx;
			@(posedge pclk);
		end
		overload_now <= 16'h0000;
		repeat (2) @(posedge pclk);
		rdc(IDX_PEAK, {16'h0000, mx});
		cmd(PC_PEAK_CLR);
		rdc(IDX_PEAK, ZERO32);
		overload_now <= 16'h0123;
		repeat (2) @(posedge pclk);
		overload_now <= 16'h0000;
		servo_on <= 1'b0;
		// Software reset reloads position and clears the peak.
		// A power-up-only setting waits for the software reset.
		apb(1'b1, IDX_ABS_CFG, 32'h0000_0002);
		rdc(IDX_STATUS, 32'h0001_0000);
		sr_seen = 1'b0;
		cmd(PC_SOFT_RST);
		wait_idle();
		`CHK(sr_seen, 1'b1)
		rdc(IDX_POS_ACT, exp_pos(ZERO32, hofs));
		rdc(IDX_STATUS, 32'h0002_0000);
		rdc(IDX_PEAK, ZERO32);
		// Tuning with a small offset, then one over the alarm limit.
		lf = lfsr_next(lf);
		pa = {9'h000, lf[6:0]};
		phase_set <= {16'h0040, -pa, pa};
		cmd(PC_TUNE);
		wait_idle();
		rdc(IDX_PH_A, {16'h0000, pa});
		rdc(IDX_PH_B, {16'h0000, -pa});
		rdc(IDX_PH_C, 32'h0000_0040);
		`CHK(phase_offset_alarm, 1'b0)
		phase_set <= {16'h0040, -pa, 16'd300};
		cmd(PC_TUNE);
		wait_idle();
		`CHK(phase_offset_alarm, 1'b1)
		// Rotor alignment for two milliseconds.
		lf = lfsr_next(lf);
		apb(1'b1, IDX_ALN_METHOD, {16'h0000, lf});
		apb(1'b1, IDX_ALN_CURRENT, {16'h0000, ~lf});
		apb(1'b1, IDX_ALN_TIME, 32'h0000_0002);
		aln_cnt = 0;
		cmd(PC_ALIGN);
		wait_idle();
		`CHK(align_method, lf)
		`CHK(align_current, ~lf)
		`CHK(aln_cnt >= 20 && aln_cnt <= 24, 1'b1)
		tally_and_finish();
	end
endmodule
